// *** core/emac_pkg.sv ***
package emac_pkg;
   // One nibble of the PHY data path with its frame-valid flag
   typedef struct packed {
      logic en;
      logic [3:0] nib;
   } mii_t;
   typedef enum logic [2:0] {
      T_IDLE = 3'b000,
      T_PRE = 3'b001,
      T_BODY = 3'b010,
      T_PAD = 3'b011,
      T_FCS = 3'b100
   } tx_st_t;
   typedef enum logic [2:0] {
      R_IDLE = 3'b000,
      R_SFD = 3'b001,
      R_BODY = 3'b010,
      R_DROP = 3'b011,
      R_FLUSH = 3'b100,
      R_COMMIT = 3'b101
   } rx_st_t;
endpackage

// *** core/ethernet_mac_frame_fifo.sv ***
// Summary of operation
// - Fields in order, octets LSB first
// - Seven preamble octets start each frame
// - Start delimiter 1010.1011 follows preamble
// - Destination bit zero marks group address
// - Length/type above 1500 means type
// - Length/type carried high octet first
// - Pad data field to 46 when enabled
// - No too-long error, only overflow
// - CRC-32 over addresses, type, data, pad
// - CRC advances one nibble per step
// - Append check value when CRC bit set
// - Drop bad-check frames unless disabled
// - Concurrent transmit/receive only in duplex; in half duplex both still start if ready in the same cycle
// - Transmit buffer holds one frame
// - Transmit payload up to 2032 bytes
// - Receive buffer holds up to 31 frames
// - Set overflow flag when frame won't fit
// - Receive word0 holds total frame length
// - Each received frame starts word aligned
// - Word0 length then destination octets 1-2
// - Then destination octets 3-6, source, type, data, check octets
// - Nothing sent until transmit enable set
// - Filter on station, promiscuous, multicast
`timescale 1ns/1ps
`include "ethernet_mac_frame_fifo_consts.svh"
module ethernet_mac_frame_fifo #(
   parameter int TX_AW = 9,
   parameter int RX_AW = 9,
   parameter int MAX_FRAMES = 31
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output emac_pkg::mii_t tx_mii,
   input wire emac_pkg::mii_t rx_mii
);

////////////////////////////////////////////////////////////////////////////
logic [3:0] tx_ctl_ff;
logic [3:0] rx_ctl_ff;
logic [31:0] sta_lo_ff;
logic [15:0] sta_hi_ff;
logic [3:0] ris_ff;
logic tx_req_ff;
logic [31:0] rdata_ff;
logic [31:0] tx_mem [2**TX_AW];
logic [TX_AW:0] twp_ff;
emac_pkg::tx_st_t tx_st_ff;
logic [11:0] tcnt_ff;
logic [5:0] k_ff;
logic tph_ff;
logic [31:0] tcrc_ff;
emac_pkg::mii_t tx_out_ff;
logic [31:0] rx_mem [2**RX_AW];
logic [RX_AW:0] cm_ptr_ff;
logic [RX_AW:0] rd_ptr_ff;
logic [11:0] rem_ff;
logic [5:0] cnt_ff;
emac_pkg::rx_st_t rx_st_ff;
logic [11:0] rk_ff;
logic rph_ff;
logic [3:0] rlo_ff;
logic [31:0] rcrc_ff;
logic [31:0] asm_ff;
logic [15:0] hold_ff;
logic [47:0] da_ff;
logic da_ok_ff;
logic [15:0] lt_ff;
logic typed_ff;
logic mcast_ff;

// Nibble-wide reflected CRC step
function automatic logic [31:0] crc_nib(input logic [31:0] c,
                                        input logic [3:0] d);
   logic [31:0] r;
   r = c;
   for (int i = 0; i < 4; i++) begin
      r = (r >> 1) ^ ((r[0] ^ d[i]) ? `CRC_POLY : 32'h0000_0000);
   end
   return r;
endfunction

////////////////////////////////////////////////////////////////////////////
// Register decode
logic wr_dat;
logic rd_dat;
logic rst_fifo;
assign wr_dat = reg_wr && reg_addr == `REG_DATA;
assign rd_dat = reg_rd && reg_addr == `REG_DATA;
assign rst_fifo = reg_wr && reg_addr == `REG_RX_CTL
   && reg_wdata[`RXC_RST];

// Control and station address registers
always_ff @(posedge sys_clk) begin
   if (srst) begin
      tx_ctl_ff <= `TXC_RESET;
      rx_ctl_ff <= `RXC_RESET;
      sta_lo_ff <= 32'h0000_0000;
      sta_hi_ff <= 16'h0000;
   end else if (reg_wr) begin
      case (reg_addr)
         `REG_TX_CTL: tx_ctl_ff <= reg_wdata[3:0];
         `REG_RX_CTL: rx_ctl_ff <= reg_wdata[3:0];
         `REG_STA_LO: sta_lo_ff <= reg_wdata;
         `REG_STA_HI: sta_hi_ff <= reg_wdata[15:0];
         default: ;
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////
// Transmit datapath decode
logic crc_on;
logic tx_go;
logic tx_done;
logic [11:0] tx_len;
logic [11:0] t_last;
logic [11:0] tx_pad_n;
logic pad_need;
logic [31:0] tx_word;
logic [7:0] tbuf_byte;
logic [7:0] fcs_byte;
logic [7:0] t_byte;
logic [3:0] t_nib;
logic [31:0] fcs_val;

assign crc_on = tx_ctl_ff[`TXC_CRC];
assign tx_len = tx_mem[0][11:0];
assign t_last = `HDR_END + tx_len;
assign tx_pad_n = `MIN_DATA - tx_len;
assign pad_need = tx_ctl_ff[`TXC_PAD] && tx_len < `MIN_DATA;
assign tx_word = tx_mem[tcnt_ff[TX_AW+1:2]];
assign tbuf_byte = tx_word[{tcnt_ff[1:0], 3'b000} +: 8];
assign fcs_val = ~tcrc_ff;
assign fcs_byte = fcs_val[{k_ff[1:0], 3'b000} +: 8];
assign tx_go = tx_st_ff == emac_pkg::T_IDLE && tx_req_ff
   && tx_ctl_ff[`TXC_EN]
   && (tx_ctl_ff[`TXC_DUPLEX] || rx_st_ff == emac_pkg::R_IDLE);
assign tx_done = tx_st_ff == emac_pkg::T_FCS && tph_ff
   && k_ff == `FCS_LAST;

// Octet source per phase of the frame
always_comb begin
   case (tx_st_ff)
      emac_pkg::T_PRE: t_byte = (k_ff == `PRE_LAST) ? `SFD_BYTE
         : `PRE_BYTE;
      emac_pkg::T_BODY: t_byte = tbuf_byte;
      emac_pkg::T_FCS: t_byte = crc_on ? fcs_byte : tbuf_byte;
      default: t_byte = 8'h00;
   endcase
end

// Low nibble goes first
assign t_nib = tph_ff ? t_byte[7:4] : t_byte[3:0];

// Transmit buffer fill, one frame at a time
always_ff @(posedge sys_clk) begin
   if (wr_dat && !tx_req_ff && !twp_ff[TX_AW]) begin
      tx_mem[twp_ff[TX_AW-1:0]] <= reg_wdata;
   end
end

always_ff @(posedge sys_clk) begin
   if (srst || tx_done) begin
      twp_ff <= '0;
   end else if (wr_dat && !tx_req_ff && !twp_ff[TX_AW]) begin
      twp_ff <= twp_ff + 1'b1;
   end
end

// Send request, set by software and ended by the sequencer
always_ff @(posedge sys_clk) begin
   if (srst) begin
      tx_req_ff <= 1'b0;
   end else if (reg_wr && reg_addr == `REG_TX_REQ && reg_wdata[0]) begin
      tx_req_ff <= 1'b1;
   end else if (tx_done) begin
      tx_req_ff <= 1'b0;
   end
end

// Transmit sequencer
always_ff @(posedge sys_clk) begin
   if (srst) begin
      tx_st_ff <= emac_pkg::T_IDLE;
      tcnt_ff <= 12'h000;
      k_ff <= 6'h00;
      tph_ff <= 1'b0;
   end else begin
      case (tx_st_ff)
         emac_pkg::T_IDLE: begin
            k_ff <= 6'h00;
            tph_ff <= 1'b0;
            if (tx_go) begin
               tx_st_ff <= emac_pkg::T_PRE;
            end
         end
         emac_pkg::T_PRE: begin
            tph_ff <= ~tph_ff;
            if (tph_ff) begin
               k_ff <= k_ff + 6'h01;
               if (k_ff == `PRE_LAST) begin
                  tx_st_ff <= emac_pkg::T_BODY;
                  tcnt_ff <= `HDR_SKIP;
               end
            end
         end
         emac_pkg::T_BODY: begin
            tph_ff <= ~tph_ff;
            if (tph_ff) begin
               tcnt_ff <= tcnt_ff + 12'h001;
               k_ff <= 6'h00;
               if (tcnt_ff == t_last) begin
                  tx_st_ff <= pad_need ? emac_pkg::T_PAD : emac_pkg::T_FCS;
               end
            end
         end
         emac_pkg::T_PAD: begin
            tph_ff <= ~tph_ff;
            if (tph_ff) begin
               k_ff <= k_ff + 6'h01;
               if ({6'h00, k_ff} + 12'h001 == tx_pad_n) begin
                  tx_st_ff <= emac_pkg::T_FCS;
                  k_ff <= 6'h00;
               end
            end
         end
         emac_pkg::T_FCS: begin
            tph_ff <= ~tph_ff;
            if (tph_ff) begin
               k_ff <= k_ff + 6'h01;
               tcnt_ff <= tcnt_ff + 12'h001;
               if (k_ff == `FCS_LAST) begin
                  tx_st_ff <= emac_pkg::T_IDLE;
               end
            end
         end
         default: tx_st_ff <= emac_pkg::T_IDLE;
      endcase
   end
end

// Transmit CRC over header, data and pad
always_ff @(posedge sys_clk) begin
   if (srst || tx_st_ff == emac_pkg::T_IDLE
       || tx_st_ff == emac_pkg::T_PRE) begin
      tcrc_ff <= `CRC_INIT;
   end else if (tx_st_ff == emac_pkg::T_BODY
                || tx_st_ff == emac_pkg::T_PAD) begin
      tcrc_ff <= crc_nib(tcrc_ff, t_nib);
   end
end

// Registered nibble towards the PHY
always_ff @(posedge sys_clk) begin
   if (srst) begin
      tx_out_ff <= '0;
   end else begin
      tx_out_ff.en <= tx_st_ff != emac_pkg::T_IDLE;
      tx_out_ff.nib <= t_nib;
   end
end
assign tx_mii = tx_out_ff;

////////////////////////////////////////////////////////////////////////////
// Receive datapath decode
logic [RX_AW:0] rx_free;
logic [11:0] r_idx;
logic [11:0] need_w;
logic ovf_byte;
logic byte_ok;
logic [7:0] rx_byte;
logic [47:0] da_next;
logic da_match;
logic full_frames;
logic rx_go;
logic crc_bad;
logic rwe;
logic [11:0] roff;
logic [31:0] rwd;
logic pop;
logic [31:0] rx_head;

assign rx_free = (RX_AW+1)'(2**RX_AW) - (cm_ptr_ff - rd_ptr_ff);
assign r_idx = rk_ff + `HDR_SKIP;
assign need_w = {2'b00, r_idx[11:2]} + 12'h001;
assign ovf_byte = need_w > 12'(rx_free);
assign byte_ok = rx_st_ff == emac_pkg::R_BODY && rx_mii.en && rph_ff;
assign rx_byte = {rx_mii.nib, rlo_ff};
assign da_next = {rx_byte, da_ff[47:8]};
assign da_match = da_next == {sta_hi_ff, sta_lo_ff}
   || rx_ctl_ff[`RXC_PROMISCUOUS_BIT]
   || (rx_ctl_ff[`RXC_ALL_MULTICAST_BIT] && da_next[0]);
assign full_frames = cnt_ff >= 6'(MAX_FRAMES);
assign rx_go = rx_st_ff == emac_pkg::R_IDLE && rx_mii.en
   && rx_ctl_ff[`RXC_EN]
   && (tx_ctl_ff[`TXC_DUPLEX] || tx_st_ff == emac_pkg::T_IDLE);
assign crc_bad = rcrc_ff != `CRC_RESIDUE;

// Receive sequencer
always_ff @(posedge sys_clk) begin
   if (srst) begin
      rx_st_ff <= emac_pkg::R_IDLE;
      rk_ff <= 12'h000;
      rph_ff <= 1'b0;
      da_ok_ff <= 1'b0;
   end else begin
      case (rx_st_ff)
         emac_pkg::R_IDLE: begin
            if (rx_go) begin
               rx_st_ff <= full_frames ? emac_pkg::R_DROP
                  : emac_pkg::R_SFD;
            end
         end
         emac_pkg::R_SFD: begin
            rk_ff <= 12'h000;
            rph_ff <= 1'b0;
            da_ok_ff <= 1'b0;
            if (!rx_mii.en) begin
               rx_st_ff <= emac_pkg::R_IDLE;
            end else if (rx_mii.nib == `SFD_HI) begin
               rx_st_ff <= emac_pkg::R_BODY;
            end
         end
         emac_pkg::R_BODY: begin
            if (!rx_mii.en) begin
               rx_st_ff <= emac_pkg::R_FLUSH;
            end else begin
               rph_ff <= ~rph_ff;
               if (rph_ff) begin
                  rk_ff <= rk_ff + 12'h001;
                  if (ovf_byte) begin
                     rx_st_ff <= emac_pkg::R_DROP;
                  end else if (rk_ff == `DA_LAST) begin
                     da_ok_ff <= da_match;
                     if (!da_match) begin
                        rx_st_ff <= emac_pkg::R_DROP;
                     end
                  end
               end
            end
         end
         emac_pkg::R_DROP: begin
            if (!rx_mii.en) begin
               rx_st_ff <= emac_pkg::R_IDLE;
            end
         end
         emac_pkg::R_FLUSH: begin
            if (!da_ok_ff || (rx_ctl_ff[`RXC_REJECT] && crc_bad)) begin
               rx_st_ff <= emac_pkg::R_IDLE;
            end else begin
               rx_st_ff <= emac_pkg::R_COMMIT;
            end
         end
         default: rx_st_ff <= emac_pkg::R_IDLE;
      endcase
   end
end

// Byte assembly, header capture and receive CRC
always_ff @(posedge sys_clk) begin
   if (srst) begin
      rlo_ff <= 4'h0;
      asm_ff <= 32'h0000_0000;
      hold_ff <= 16'h0000;
      da_ff <= '0;
      lt_ff <= 16'h0000;
      rcrc_ff <= `CRC_INIT;
   end else begin
      if (rx_st_ff == emac_pkg::R_SFD) begin
         rcrc_ff <= `CRC_INIT;
      end else if (rx_st_ff == emac_pkg::R_BODY && rx_mii.en) begin
         rcrc_ff <= crc_nib(rcrc_ff, rx_mii.nib);
         if (!rph_ff) begin
            rlo_ff <= rx_mii.nib;
         end
      end
      if (byte_ok) begin
         asm_ff[{r_idx[1:0], 3'b000} +: 8] <= rx_byte;
         if (r_idx == 12'h003) begin
            hold_ff <= {rx_byte, asm_ff[23:16]};
         end
         if (rk_ff <= `DA_LAST) begin
            da_ff <= da_next;
         end
         if (rk_ff == `LT_HI || rk_ff == `LT_LO) begin
            lt_ff <= {lt_ff[7:0], rx_byte};
         end
      end
   end
end

// Single write port into the receive buffer
always_comb begin
   rwe = 1'b0;
   roff = 12'h000;
   rwd = asm_ff;
   case (rx_st_ff)
      emac_pkg::R_BODY: begin
         rwe = byte_ok && !ovf_byte && r_idx[1:0] == 2'b11
            && r_idx[11:2] != 10'h000;
         roff = {2'b00, r_idx[11:2]};
         rwd = {rx_byte, asm_ff[23:0]};
      end
      emac_pkg::R_FLUSH: begin
         rwe = r_idx[1:0] != 2'b00;
         roff = {2'b00, r_idx[11:2]};
      end
      emac_pkg::R_COMMIT: begin
         rwe = 1'b1;
         rwd = {hold_ff, 4'h0, rk_ff};
      end
      default: rwe = 1'b0;
   endcase
end

// Frames are laid out from the committed pointer
always_ff @(posedge sys_clk) begin
   if (rwe) begin
      rx_mem[cm_ptr_ff[RX_AW-1:0] + roff[RX_AW-1:0]] <= rwd;
   end
end

// Pointers, pending frame count and word bookkeeping
assign pop = rd_dat && rd_ptr_ff != cm_ptr_ff;
assign rx_head = rx_mem[rd_ptr_ff[RX_AW-1:0]];

always_ff @(posedge sys_clk) begin
   if (srst || rst_fifo) begin
      cm_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      rem_ff <= 12'h000;
      cnt_ff <= 6'h00;
   end else begin
      if (rx_st_ff == emac_pkg::R_COMMIT) begin
         cm_ptr_ff <= cm_ptr_ff
            + (RX_AW+1)'((rk_ff + 12'h005) >> 2);
      end
      if (pop) begin
         rd_ptr_ff <= rd_ptr_ff + 1'b1;
         rem_ff <= (rem_ff == 12'h000)
            ? ((rx_head[11:0] + 12'h001) >> 2) : rem_ff - 12'h001;
      end
      cnt_ff <= cnt_ff + {5'h00, rx_st_ff == emac_pkg::R_COMMIT}
         - {5'h00, pop && rem_ff == 12'h000};
   end
end

// Last accepted frame classification
always_ff @(posedge sys_clk) begin
   if (srst) begin
      typed_ff <= 1'b0;
      mcast_ff <= 1'b0;
   end else if (rx_st_ff == emac_pkg::R_COMMIT) begin
      typed_ff <= lt_ff > `MAX_LEN;
      mcast_ff <= da_ff[0];
   end
end

////////////////////////////////////////////////////////////////////////////
// Raw status, write one to clear, a new event wins
logic [3:0] ev;
assign ev[`ST_RX_DONE] = rx_st_ff == emac_pkg::R_COMMIT;
assign ev[`ST_TX_DONE] = tx_done;
assign ev[`ST_RX_ERR] = rx_st_ff == emac_pkg::R_FLUSH && da_ok_ff
   && rx_ctl_ff[`RXC_REJECT] && crc_bad;
assign ev[`ST_OVF] = (byte_ok && ovf_byte) || (rx_go && full_frames);

always_ff @(posedge sys_clk) begin
   if (srst) begin
      ris_ff <= 4'h0;
   end else if (reg_wr && reg_addr == `REG_STATUS) begin
      ris_ff <= (ris_ff & ~reg_wdata[3:0]) | ev;
   end else begin
      ris_ff <= ris_ff | ev;
   end
end

// Read data, valid the cycle after the strobe
always_ff @(posedge sys_clk) begin
   if (srst) begin
      rdata_ff <= 32'h0000_0000;
   end else if (reg_rd) begin
      case (reg_addr)
         `REG_STATUS: rdata_ff <= {28'h0000000, ris_ff};
         `REG_RX_CTL: rdata_ff <= {28'h0000000, rx_ctl_ff};
         `REG_TX_CTL: rdata_ff <= {28'h0000000, tx_ctl_ff};
         `REG_STA_LO: rdata_ff <= sta_lo_ff;
         `REG_STA_HI: rdata_ff <= {16'h0000, sta_hi_ff};
         `REG_DATA: rdata_ff <= pop ? rx_head : 32'h0000_0000;
         `REG_TX_REQ: rdata_ff <= {30'h00000000,
            tx_st_ff != emac_pkg::T_IDLE, tx_req_ff};
         `REG_RX_INFO: rdata_ff <= {16'h0000, 6'h00, mcast_ff, typed_ff,
            2'b00, cnt_ff};
         default: rdata_ff <= 32'h0000_0000;
      endcase
   end
end
assign reg_rdata = rdata_ff;

endmodule

// *** core/ethernet_mac_frame_fifo_consts.svh ***
`ifndef ETHERNET_MAC_FRAME_FIFO_CONSTS_SVH
`define ETHERNET_MAC_FRAME_FIFO_CONSTS_SVH
// Register byte addresses
`define REG_STATUS 8'h00
`define REG_RX_CTL 8'h04
`define REG_TX_CTL 8'h08
`define REG_STA_LO 8'h0C
`define REG_STA_HI 8'h10
`define REG_DATA 8'h14
`define REG_TX_REQ 8'h18
`define REG_RX_INFO 8'h1C
// Transmit control bit positions
`define TXC_EN 0
`define TXC_PAD 1
`define TXC_CRC 2
`define TXC_DUPLEX 3
`define TXC_RESET 4'h0
// Receive control bit positions
`define RXC_EN 0
`define RXC_ALL_MULTICAST_BIT 1
`define RXC_PROMISCUOUS_BIT 2
`define RXC_REJECT 3
`define RXC_RST 4
`define RXC_RESET 4'h8
// Status bit positions
`define ST_RX_DONE 0
`define ST_TX_DONE 1
`define ST_RX_ERR 2
`define ST_OVF 3
// Frame constants
`define PRE_BYTE 8'h55
`define SFD_BYTE 8'hD5
`define SFD_HI 4'hD
`define PRE_LAST 6'h07
`define FCS_LAST 6'h03
`define HDR_SKIP 12'h002
`define HDR_END 12'h00F
`define MIN_DATA 12'h02E
`define MAX_LEN 16'h05DC
`define DA_LAST 12'h005
`define LT_HI 12'h00C
`define LT_LO 12'h00D
`define CRC_INIT 32'hFFFF_FFFF
`define CRC_POLY 32'hEDB8_8320
`define CRC_RESIDUE 32'hDEBB_20E3
`endif

// *** tb/emac_checker_assertions.sv ***
`timescale 1ns/1ps
`include "ethernet_mac_frame_fifo_consts.svh"
module emac_checker #(
   parameter int MAX_FRAMES = 31
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire emac_pkg::mii_t tx_mii
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic [3:0] tctl_ff;
   logic [12:0] run_ff;
   ////////////////////////////////////////////////////////////////////////
   // Shadow of the transmit control bits
   always_ff @(posedge sys_clk)
      if (srst) tctl_ff <= `TXC_RESET;
      else if (reg_wr && reg_addr == `REG_TX_CTL) tctl_ff <= reg_wdata[3:0];
   // Nibbles seen in the current frame
   always_ff @(posedge sys_clk)
      if (srst || !tx_mii.en) run_ff <= 13'h0000;
      else run_ff <= run_ff + 13'h0001;
   ////////////////////////////////////////////////////////////////////////
   // Transmit framing
   preamble_run_a: assert property (
      $rose(tx_mii.en) |-> (tx_mii.en && tx_mii.nib == 4'h5) [*8] ##1
      (tx_mii.en && tx_mii.nib == 4'h5) [*7] ##1 tx_mii.nib == `SFD_HI)
      else $error("bad preamble");
   tx_gate_a: assert property (
      $rose(tx_mii.en) |-> tctl_ff[`TXC_EN] && $past(tctl_ff[`TXC_EN]))
      else $error("sent while disabled");
   tx_quiet_a: assert property (
      !tctl_ff[`TXC_EN] && !tx_mii.en |=> !tx_mii.en)
      else $error("started while disabled");
   whole_octet_a: assert property (
      $fell(tx_mii.en) |-> !run_ff[0])
      else $error("odd nibble count");
   pad_floor_a: assert property (
      $fell(tx_mii.en) && tctl_ff[`TXC_PAD] && tctl_ff[`TXC_CRC]
      |-> run_ff >= 13'h0090)
      else $error("padded frame too short");
   // Register reads
   frame_cap_a: assert property (
      reg_rd && reg_addr == `REG_RX_INFO |=> reg_rdata[5:0] <= MAX_FRAMES)
      else $error("pending count too high");
   unmapped_rd_a: assert property (
      reg_rd && reg_addr == 8'h20 |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data moved");
endmodule
bind ethernet_mac_frame_fifo emac_checker #(.MAX_FRAMES(MAX_FRAMES)) u_chk (
   .sys_clk(sys_clk),
   .srst(srst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .tx_mii(tx_mii)
);

// *** tb/emac_phy_model.sv ***
`timescale 1ns/1ps
module emac_phy_model (
   input wire logic sys_clk,
   input wire emac_pkg::mii_t tx_mii,
   output emac_pkg::mii_t rx_mii
);
   logic [7:0] cap[$];
   logic [3:0] nq[$];
   logic [3:0] lo = 4'h0;
   logic half = 1'b0;
   // Gather sent octets, low nibble first
   always @(posedge sys_clk)
      if (!tx_mii.en) half <= 1'b0;
      else begin
         if (half) cap.push_back({tx_mii.nib, lo});
         lo <= tx_mii.nib;
         half <= ~half;
      end
   // Play queued nibbles; idle data keeps toggling
   initial rx_mii = '0;
   always @(posedge sys_clk)
      if (nq.size() > 0) rx_mii <= '{1'b1, nq.pop_front()};
      else rx_mii <= '{1'b0, ~rx_mii.nib};
   // Preamble, delimiter, octets low nibble first
   task automatic send(input logic [7:0] q[$]);
      for (int i = 0; i < 15; i++) nq.push_back(4'h5);
      nq.push_back(4'hD);
      foreach (q[i]) begin
         nq.push_back(q[i][3:0]);
         nq.push_back(q[i][7:4]);
      end
      wait (nq.size() == 0);
      repeat (6) @(posedge sys_clk);
   endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "ethernet_mac_frame_fifo_consts.svh"
module tb;
   typedef logic [7:0] bq_t[$];
   localparam logic [47:0] STA = 48'h6655_4433_2211;
   logic sys_clk = 1'b0;
   logic srst;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   emac_pkg::mii_t tx_mii;
   emac_pkg::mii_t rx_mii;
   logic both = 1'b0;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   ethernet_mac_frame_fifo #(.RX_AW(6)) u_dut (
      .sys_clk(sys_clk),
      .srst(srst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .tx_mii(tx_mii),
      .rx_mii(rx_mii)
   );
   emac_phy_model u_phy (.sys_clk(sys_clk), .tx_mii(tx_mii), .rx_mii(rx_mii));
   ////////////////////////////////////////////////////////////////////////
   // Clock, overlap watch and run limit
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (tx_mii.en && rx_mii.en) both <= 1'b1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   // Register bus cycles
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata & m, e);
   endtask
   // Frame building
   function automatic bq_t mk(input logic [47:0] da, input logic [15:0] lt,
         input int n);
      bq_t q;
      for (int k = 0; k < 6; k++) q.push_back(da[8*k +: 8]);
      for (int k = 0; k < 6; k++) q.push_back(8'hA0 + 8'(k));
      q.push_back(lt[15:8]);
      q.push_back(lt[7:0]);
      for (int k = 0; k < n; k++) q.push_back(8'(3 * k + 1));
      return q;
   endfunction
   function automatic bq_t add_fcs(input bq_t q, input bit bad);
      logic [31:0] c;
      c = 32'hFFFF_FFFF;
      foreach (q[i]) begin
         c = c ^ {24'h0, q[i]};
         for (int k = 0; k < 8; k++)
            c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
      end
      c = ~c ^ {31'h0, bad};
      for (int k = 0; k < 4; k++) q.push_back(c[8*k +: 8]);
      return q;
   endfunction
   function automatic logic [31:0] pick(input bq_t s, input int i,
         input bit m);
      logic [31:0] w;
      w = 32'h0;
      for (int k = 0; k < 4; k++)
         if (i + k < s.size()) w[8*k +: 8] = m ? 8'hFF : s[i + k];
      return w;
   endfunction
   task automatic load(input bq_t s);
      for (int i = 0; i < s.size(); i += 4) wr(`REG_DATA, pick(s, i, 1'b0));
      wr(`REG_TX_REQ, 32'h1);
   endtask
   task automatic tx_cmp(input bq_t b);
      int i;
      i = 0;
      while (!tx_mii.en && i < 40) begin
         @(posedge sys_clk);
         i++;
      end
      while (tx_mii.en && i < 4000) begin
         @(posedge sys_clk);
         i++;
      end
      repeat (2) @(posedge sys_clk);
      b = {8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'hD5, b};
      chk(32'(u_phy.cap.size()), 32'(b.size()));
      foreach (b[k])
         if (k < u_phy.cap.size()) chk(32'(u_phy.cap[k]), 32'(b[k]));
   endtask
   task automatic rx_read(input bq_t f);
      bq_t s;
      s = {8'(f.size()), 8'(f.size() >> 8), f};
      for (int i = 0; i < s.size(); i += 4)
         rdc(`REG_DATA, pick(s, i, 1'b1), pick(s, i, 1'b0));
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_tx_gate();
      bq_t fr;
      fr = mk(STA, 16'h0800, 4);
      u_phy.cap.delete();
      load({8'h04, 8'h00, fr});
      repeat (40) @(posedge sys_clk);
      chk(32'(u_phy.cap.size()), 32'h0);
      rdc(`REG_TX_REQ, 32'h3, 32'h1);
      wr(`REG_TX_CTL, 32'h7);
      while (fr.size() < 60) fr.push_back(8'h00);
      tx_cmp(add_fcs(fr, 1'b0));
      rdc(`REG_STATUS, 32'h3, 32'h2);
      $display("test tx_gate done");
   endtask
   task automatic t_tx_raw();
      bq_t f;
      f = add_fcs(mk(STA, 16'h0005, 5), 1'b0);
      wr(`REG_TX_CTL, 32'h1);
      u_phy.cap.delete();
      load({8'h05, 8'h00, f});
      tx_cmp(f);
      $display("test tx_raw done");
   endtask
   task automatic t_duplex();
      bq_t t;
      t = add_fcs(mk(STA, 16'h0004, 4), 1'b0);
      wr(`REG_RX_CTL, 32'h1);
      for (int d = 0; d < 2; d++) begin
         wr(`REG_TX_CTL, d ? 32'h9 : 32'h1);
         both = 1'b0;
         u_phy.cap.delete();
         fork
            u_phy.send(mk(STA, 16'h0800, 40));
            begin
               repeat (20) @(posedge sys_clk);
               load({8'h04, 8'h00, t});
            end
         join
         tx_cmp(t);
         chk(32'(both), 32'(d));
      end
      wr(`REG_RX_CTL, 32'h10);
      $display("test duplex done");
   endtask
   task automatic t_rx();
      bq_t a;
      bq_t b;
      a = add_fcs(mk(STA, 16'h0005, 5), 1'b0);
      b = add_fcs(mk(STA, 16'h0002, 2), 1'b0);
      wr(`REG_RX_CTL, 32'h9);
      wr(`REG_STATUS, 32'hF);
      u_phy.send(a);
      u_phy.send(b);
      rdc(`REG_RX_INFO, 32'h3F, 32'h2);
      rdc(`REG_STATUS, 32'h5, 32'h1);
      rx_read(a);
      rx_read(b);
      rdc(`REG_RX_INFO, 32'h3F, 32'h0);
      rdc(`REG_DATA, 32'hFFFF_FFFF, 32'h0);
      $display("test rx done");
   endtask
   task automatic t_bad();
      bq_t a;
      a = add_fcs(mk(STA, 16'h0004, 4), 1'b1);
      u_phy.send(a);
      rdc(`REG_RX_INFO, 32'h3F, 32'h0);
      rdc(`REG_STATUS, 32'h4, 32'h4);
      wr(`REG_RX_CTL, 32'h1);
      u_phy.send(a);
      rdc(`REG_RX_INFO, 32'h3F, 32'h1);
      rx_read(a);
      $display("test bad_check done");
   endtask
   task automatic t_filter();
      bq_t f;
      logic acc;
      for (int i = 0; i < 4; i++) begin
         acc = (i == 1) || (i == 2);
         wr(`REG_RX_CTL, 32'h10);
         wr(`REG_RX_CTL, (i == 1) ? 32'hB : (i == 2) ? 32'hD : 32'h9);
         f = mk({40'h0, 7'h55, i[0]}, 16'h05DC + 16'(i[0]), 20);
         u_phy.send(add_fcs(f, 1'b0));
         rdc(`REG_RX_INFO, acc ? 32'h33F : 32'h3F,
            {22'h0, {2{acc & i[0]}}, 8'(acc)});
      end
      $display("test filter done");
   endtask
   task automatic t_ovf();
      wr(`REG_RX_CTL, 32'h10);
      wr(`REG_RX_CTL, 32'h1);
      wr(`REG_STATUS, 32'hF);
      u_phy.send(add_fcs(mk(STA, 16'h0800, 300), 1'b0));
      rdc(`REG_STATUS, 32'hC, 32'h8);
      rdc(`REG_RX_INFO, 32'h3F, 32'h0);
      rdc(8'h20, 32'hFFFF_FFFF, 32'h0);
      $display("test overflow done");
   endtask
   // Main sequence
   initial begin
      srst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      rdc(`REG_STATUS, 32'hF, 32'h0);
      wr(`REG_STA_LO, STA[31:0]);
      wr(`REG_STA_HI, {16'h0, STA[47:32]});
      t_tx_gate();
      t_tx_raw();
      t_duplex();
      t_rx();
      t_bad();
      t_filter();
      t_ovf();
      give_verdict();
   end
endmodule
